// ==== rtl/agt_pkg.sv ====
package agt_pkg;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [3:0]  CTRL_OFF       = 4'h0;
  localparam logic [3:0]  COUNT_OFF      = 4'h4;
  localparam logic [3:0]  PERIOD_OFF     = 4'h8;
  localparam logic [3:0]  STAT_OFF       = 4'hC;

  // Field positions in the timer control word.
  localparam int          CTRL_ON_BIT    = 15;
  localparam int          CTRL_WDIS_BIT  = 12;
  localparam int          CTRL_WIP_BIT   = 11;
  localparam int          CTRL_GATE_BIT  = 7;
  localparam int          CTRL_PS_HI     = 5;
  localparam int          CTRL_PS_LO     = 4;
  localparam int          CTRL_ASYNC_BIT = 2;
  localparam int          CTRL_SLEEP_BIT = 0;

  // Reset values.
  localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
  localparam logic [15:0] PERIOD_RST     = 16'hFFFF;
  localparam logic [15:0] COUNT_RST      = 16'h0000;

  // Anomaly figures.
  localparam logic [2:0]  WAKE_HOLD_EDGES = 3'h5;
  localparam logic [15:0] PERIOD_NO_ROLL  = 16'h0001;
  localparam logic [2:0]  WRITE_GAP_CYC   = 3'h4;

  // AXI responses.
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

endpackage : agt_pkg

// ==== rtl/agt_timer.sv ====
// Contract
// - Async mode: after wake from sleep, count holds for first 5 external edges.
// - Async counter mode drops the first prescaled count tick (the first external rising edge at prescale 1).
// - Async mode with period 0x01 never rolls over, keeps counting.
// - Write-disable bit 12 and write-in-progress bit 11 do nothing.
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
module agt_timer
  import agt_pkg::*;
#(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // External count input and gate pin
  input  wire logic              external_count_input,
  input  wire logic              gate_in,
  // AXI4-Lite write address
  input  wire logic [3:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [3:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Status
  output logic                   period_match_q
);

  logic [31:0]      ctrl_q;
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] period_q;
  logic [2:0]       ext_sync_q;
  logic [2:0]       gate_sync_q;
  logic             ext_lvl_q;
  logic             gate_lvl_q;
  logic             first_edge_q;
  logic [2:0]       wake_cnt_q;
  logic             sleep_prev_q;
  logic [7:0]       ps_cnt_q;
  logic [2:0]       wr_gap_q;
  logic [3:0]       awaddr_q;
  logic             aw_have_q;
  logic [31:0]      wdata_q;
  logic [3:0]       wstrb_q;
  logic             w_have_q;

  wire logic on_w    = ctrl_q[CTRL_ON_BIT];
  wire logic async_w = ctrl_q[CTRL_ASYNC_BIT];
  wire logic gate_w  = ctrl_q[CTRL_GATE_BIT];
  wire logic sleep_w = ctrl_q[CTRL_SLEEP_BIT];
  wire logic [1:0] ps_sel_w = ctrl_q[CTRL_PS_HI:CTRL_PS_LO];

  // Three-flop pin input; a change counts when the last two agree.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_sync_q  <= 3'h0;
      gate_sync_q <= 3'h0;
      ext_lvl_q   <= 1'b0;
      gate_lvl_q  <= 1'b0;
    end else begin
      ext_sync_q  <= {ext_sync_q[1:0], external_count_input};
      gate_sync_q <= {gate_sync_q[1:0], gate_in};
      if (ext_sync_q[2] == ext_sync_q[1]) begin
        ext_lvl_q <= ext_sync_q[2];
      end
      if (gate_sync_q[2] == gate_sync_q[1]) begin
        gate_lvl_q <= gate_sync_q[2];
      end
    end
  end

  // Synchroniser flops reset low, the idle level of both pins, so no false edge follows reset.
  wire logic ext_rise_w = (ext_sync_q[2] == ext_sync_q[1]) && ext_sync_q[2] && !ext_lvl_q;

  // Source tick: external edge in async mode, else bus clock (gate applied).
  logic src_tick;
  always_comb begin
    src_tick = 1'b0;
    if (on_w) begin
      if (async_w) begin
        src_tick = ext_rise_w;
      end else if (gate_w) begin
        // Gating with prescaler follows the plain path; that mix is unsupported.
        // gated prescaler unsupported
        src_tick = gate_lvl_q;
      end else begin
        src_tick = 1'b1;
      end
    end
  end

  // Prescaler of 1, 8, 64 or 256.
  // The divider counts source ticks, so in async mode it divides external edges.
  logic [7:0] ps_max;
  always_comb begin
    unique case (ps_sel_w)
      2'b00: ps_max = 8'h00;
      2'b01: ps_max = 8'h07;
      2'b10: ps_max = 8'h3F;
      2'b11: ps_max = 8'hFF;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ps_cnt_q <= 8'h00;
    end else if (!on_w) begin
      ps_cnt_q <= 8'h00;
    end else if (src_tick) begin
      ps_cnt_q <= (ps_cnt_q >= ps_max) ? 8'h00 : ps_cnt_q + 8'h01;
    end
  end

  wire logic ps_tick_w = src_tick && (ps_cnt_q >= ps_max);

  // Sleep exit detection and edge swallowing.
  // The wake hold counts raw external edges, so it spans five pulses at any prescale.
  wire logic wake_w = sleep_prev_q && !sleep_w;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sleep_prev_q <= 1'b0;
      wake_cnt_q   <= 3'h0;
      first_edge_q <= 1'b1;
    end else begin
      sleep_prev_q <= sleep_w;
      if (wake_w && async_w) begin
        wake_cnt_q <= WAKE_HOLD_EDGES;
      end else if (src_tick && wake_cnt_q != 3'h0) begin
        wake_cnt_q <= wake_cnt_q - 3'h1;
      end
      if (!on_w || !async_w) begin
        first_edge_q <= 1'b1;
      end else if (ps_tick_w) begin
        first_edge_q <= 1'b0;
      end
    end
  end

  // Dropped edges still step the prescaler; only the count itself is held back.
  wire logic count_en_w = ps_tick_w && !sleep_w &&
                          !(async_w && (first_edge_q || wake_cnt_q != 3'h0));

  // Bus write channel: address and data taken in either order.
  // Readies drop while a response waits, so a second write cannot overrun the first.
  wire logic wr_go_w = aw_have_q && w_have_q && !s_axi_bvalid;
  wire logic cnt_wr_w = wr_go_w && (awaddr_q == COUNT_OFF);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= 4'h0;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= {s_axi_awaddr[3:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_go_w) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_q == STAT_OFF) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !w_have_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Control word: bit 12 is stored but steers nothing, bit 11 reads zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_go_w && awaddr_q == CTRL_OFF) begin
      ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & ~(32'h1 << CTRL_WIP_BIT);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_q <= PERIOD_RST[WIDTH-1:0];
    end else if (wr_go_w && awaddr_q == PERIOD_OFF) begin
      period_q <= WIDTH'(merge(32'(period_q), wdata_q, wstrb_q));
    end
  end

  // Close count writes are accepted but the behaviour is undefined by contract.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_gap_q <= 3'h0;
    end else if (cnt_wr_w) begin
      wr_gap_q <= WRITE_GAP_CYC;
    end else if (wr_gap_q != 3'h0) begin
      wr_gap_q <= wr_gap_q - 3'h1;
    end
  end

  wire logic at_period_w = (count_q == period_q);
  wire logic roll_w = at_period_w && !(async_w && period_q == PERIOD_NO_ROLL[WIDTH-1:0]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q        <= COUNT_RST[WIDTH-1:0];
      period_match_q <= 1'b0;
    end else begin
      period_match_q <= 1'b0;
      if (cnt_wr_w) begin
        count_q <= WIDTH'(merge(32'(count_q), wdata_q, wstrb_q));
      end else if (count_en_w) begin
        if (roll_w) begin
          count_q        <= '0;
          period_match_q <= 1'b1;
        end else begin
          count_q <= count_q + 1'b1;
        end
      end
    end
  end

  // Read channel: one read at a time, data the cycle after the address.
  // Read data is captured with the address, so it cannot change while rvalid waits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        unique case ({s_axi_araddr[3:2], 2'b00})
          CTRL_OFF:   s_axi_rdata <= ctrl_q;
          COUNT_OFF:  s_axi_rdata <= 32'(count_q);
          PERIOD_OFF: s_axi_rdata <= 32'(period_q);
          STAT_OFF:   s_axi_rdata <= {24'h0, wake_cnt_q, first_edge_q, wr_gap_q != 3'h0,
                                      gate_lvl_q, ext_lvl_q, sleep_w};
          default:    s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : agt_timer

// ==== tb/agt_ext_src.sv ====
`timescale 1ns/1ns
module agt_ext_src (
  input  wire logic       aclk,
  input  wire logic       go,
  input  wire logic [3:0] pulses,
  output logic            ext,
  output logic            busy
);
  logic [6:0] phase_q;
  initial begin
    ext = 1'b0;
    busy = 1'b0;
    phase_q = 7'h00;
  end
  // Edges are spaced eight cycles apart so the three-flop synchroniser never merges two.
  always @(posedge aclk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      phase_q <= {pulses, 3'h0};
    end else if (busy) begin
      phase_q <= phase_q - 7'h01;
      ext <= phase_q[2];
      busy <= (phase_q > 7'h01);
    end
  end
endmodule : agt_ext_src

// ==== tb/agt_timer_assertions.sv ====
`timescale 1ns/1ns
module agt_timer_assertions
  import agt_pkg::*;
(
  // Clock, reset and bus
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic [3:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Timer status
  input wire logic        period_match_q
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic rd_ctrl_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) rd_ctrl_q <= 1'b0;
    else if (s_axi_arvalid && s_axi_arready) rd_ctrl_q <= (s_axi_araddr[3:2] == 2'h0);
  end
  b_stands_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  r_stands_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  w_refused_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  match_pulse_a: assert property (period_match_q |=> !period_match_q)
    else $error("period match longer than one cycle");
  wip_zero_a: assert property (s_axi_rvalid && rd_ctrl_q |-> !s_axi_rdata[CTRL_WIP_BIT])
    else $error("write in progress bit reads set");
  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  cover property (period_match_q);
  cover property (s_axi_rvalid && rd_ctrl_q);
endmodule : agt_timer_assertions
bind agt_timer agt_timer_assertions chk_u (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .period_match_q(period_match_q));

// ==== tb/async_timer_one_anomalies_tb.sv ====
`timescale 1ns/1ns
module async_timer_one_anomalies_tb;
  import agt_pkg::*;
  logic        aclk, aresetn, go, busy, ext, awv, wv, brd, arv, rrd, gt;
  logic        awr, wr_r, bv, arr, rv, mp;
  logic [3:0]  n, awa, ara, ws;
  logic [31:0] wd, rdt, rd;
  logic [1:0]  br, rr, resp;
  int          fail_count, checks_done, match_n, m0;
  agt_ext_src src_u (.aclk(aclk), .go(go), .pulses(n), .ext(ext), .busy(busy));
  agt_timer dut_u (.aclk(aclk), .aresetn(aresetn), .external_count_input(ext), .gate_in(gt),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rrd), .period_match_q(mp));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) if (mp === 1'b1) match_n <= match_n + 1;
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    awa <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    brd <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr === 1'b1) awv <= 1'b0;
      if (wr_r === 1'b1) wv <= 1'b0;
    end while (bv !== 1'b1);
    resp = br;
    brd <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask : wr
  task automatic rdr(input logic [3:0] a);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rrd <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr === 1'b1) arv <= 1'b0;
    end while (rv !== 1'b1);
    rd   = rdt;
    resp = rr;
    rrd <= 1'b0;
  endtask : rdr
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic pulse(input logic [3:0] k);
    @(posedge aclk);
    n  <= k;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    repeat (8 * k + 8) @(posedge aclk);
  endtask : pulse
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  initial begin
    {aresetn, go, awv, wv, brd, arv, rrd, gt} = '0;
    {n, awa, ara, wd} = '0;
    ws = 4'hF;
    {fail_count, checks_done, match_n} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(CTRL_OFF);
    chk("ctrl", CTRL_RST, rd);
    chk("rresp", {30'h0, RESP_OKAY}, {30'h0, resp});
    rdr(COUNT_OFF);
    chk("count", {16'h0000, COUNT_RST}, rd);
    rdr(PERIOD_OFF);
    chk("period", {16'h0000, PERIOD_RST}, rd);
    wr(STAT_OFF, 32'h0000_0000);
    chk("status bresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
    $display("test reset done");
    wr(CTRL_OFF, 32'h0000_1800);
    wr(COUNT_OFF, 32'h0000_0010);
    rdr(COUNT_OFF);
    chk("count", 32'h0000_0010, rd);
    rdr(CTRL_OFF);
    chk("ctrl", 32'h0000_1000, rd);
    $display("test write disable done");
    wr(COUNT_OFF, 32'h0000_0000);
    wr(CTRL_OFF, 32'h0000_8004);
    pulse(4'h4);
    rdr(COUNT_OFF);
    chk("count", 32'h0000_0003, rd);
    $display("test first edge done");
    wr(PERIOD_OFF, {16'h0000, PERIOD_NO_ROLL});
    wr(COUNT_OFF, 32'h0000_0000);
    m0 = match_n;
    pulse(4'h3);
    rdr(COUNT_OFF);
    chk("count", 32'h0000_0003, rd);
    chk("match pulses", 32'(m0), 32'(match_n));
    $display("test period one done");
    wr(CTRL_OFF, 32'h0000_8005);
    wr(COUNT_OFF, 32'h0000_0020);
    wr(CTRL_OFF, 32'h0000_8004);
    pulse({1'b0, WAKE_HOLD_EDGES});
    rdr(COUNT_OFF);
    chk("count", 32'h0000_0020, rd);
    pulse(4'h2);
    rdr(COUNT_OFF);
    chk("count", 32'h0000_0022, rd);
    $display("test wake done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(COUNT_OFF);
    chk("count after reset", {16'h0000, COUNT_RST}, rd);
    rdr(PERIOD_OFF);
    chk("period after reset", {16'h0000, PERIOD_RST}, rd);
    $display("test mid reset done");
    wr(CTRL_OFF, 32'h0000_0000);
    wr(PERIOD_OFF, 32'h0000_0003);
    wr(COUNT_OFF, 32'h0000_0000);
    m0 = match_n;
    wr(CTRL_OFF, 32'h0000_8000);
    repeat (40) @(posedge aclk);
    wr(CTRL_OFF, 32'h0000_0000);
    chk("rollover seen", 32'h0000_0001, {31'h0, match_n > m0});
    $display("test rollover done");
    ws <= 4'h2;
    wr(PERIOD_OFF, 32'hFFFF_FFFF);
    ws <= 4'hF;
    rdr(PERIOD_OFF);
    chk("period strobe", 32'h0000_FF03, rd);
    $display("test strobe done");
    wr(PERIOD_OFF, 32'h0000_FFFF);
    wr(COUNT_OFF, 32'h0000_0000);
    wr(CTRL_OFF, 32'h0000_8080);
    rdr(COUNT_OFF);
    chk("gated count idle", 32'h0000_0000, rd);
    gt <= 1'b1;
    repeat (10) @(posedge aclk);
    gt <= 1'b0;
    repeat (8) @(posedge aclk);
    wr(CTRL_OFF, 32'h0000_0000);
    rdr(COUNT_OFF);
    chk("gated count", 32'h0000_000A, rd);
    $display("test gate done");
    wr(COUNT_OFF, 32'h0000_0000);
    wr(CTRL_OFF, 32'h0000_8014);
    pulse(4'h8);
    rdr(COUNT_OFF);
    chk("prescaled count", 32'h0000_0000, rd);
    pulse(4'h8);
    rdr(COUNT_OFF);
    chk("prescaled count", 32'h0000_0001, rd);
    $display("test prescaler done");
    complete_run();
  end
  initial begin
    repeat (6000) @(posedge aclk);
    fail_count++;
    complete_run();
  end
endmodule : async_timer_one_anomalies_tb
